/* include/dci_pkg.sv */
// Constants shared by the daisy-chain interrupt logic.
package dci_pkg;
    localparam int unsigned NUM_SRC = 6;
    localparam logic [7:0] OPC_PREFIX = 8'hed;
    localparam logic [7:0] OPC_RETURN = 8'h4d;
    localparam logic [2:0] VEC_IDLE_CODE = 3'h3;
    localparam logic [7:0] VEC_BASE_RST = 8'h00;
    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        DCI_IDLE = 2'b00,
        DCI_PREFIX = 2'b01,
        DCI_WAIT_END = 2'b11
    } dci_fetch_e;
endpackage

/* src/dci_daisy_chain.sv */
// Daisy-chain interrupt request, acknowledge and return logic for six sources.
//
// Function
// RULE1: Request by pulling interrupt low; acknowledge is fetch and io strobes low together.
// RULE2: System ties chain enable input of the top chain member permanently high.
// RULE3: With nothing pending or in service, chain output equals chain input.
// RULE4: Anything pending or in service forces chain output low.
// RULE5: Interrupt status is frozen while the fetch strobe is low.
// RULE6: On acknowledge, only a requester with chain input high drives vector, sets in-service.
// RULE7: Processor ends each service routine by fetching the two-byte return opcode.
// RULE8: On return prefix, pending unacknowledged sources stop blocking the chain output.
// RULE9: Second byte matching right after prefix clears in-service where input high, output low.
// RULE10: Six internal sources with priority fixed in hardware.
// RULE11: Nesting allowed; each return clears only the latest acknowledged in-service latch.
// RULE12: Software return command also clears the current in-service latch.
// RULE13: Vector encodes highest pending condition; fixed code when nothing is pending.
// RULE14: Chain output follows chain input combinationally.
`timescale 1ns/100ps
module dci_daisy_chain
    import dci_pkg::*;
#(
    parameter int unsigned N_SRC = NUM_SRC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [N_SRC-1:0] i_src_req,
    input wire logic [7:0] i_vector_base,
    input wire logic i_status_affects_vector,
    input wire logic i_sw_return,
    input wire logic i_chain_enable_in,
    input wire logic i_fetch_cycle_n,
    input wire logic i_io_request_n,
    input wire logic [7:0] i_data,
    output logic o_chain_enable_out,
    output logic o_int_n,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic [N_SRC-1:0] o_in_service
);
    // Source 0 is the highest priority; the order never changes.
    logic fetch_n_s;
    logic io_request_n_n_s;
    logic fetch_n_prev_q;
    logic fetch_n_prev_d;
    logic [N_SRC-1:0] pend_q;
    logic [N_SRC-1:0] pend_d;
    logic [N_SRC-1:0] ius_q;
    logic [N_SRC-1:0] ius_d;
    logic [N_SRC-1:0] req_pend_mask;
    logic [N_SRC-1:0] pend_blocked;
    logic [N_SRC-1:0] grant;
    logic [N_SRC-1:0] top_pend;
    logic [N_SRC-1:0] top_ius;
    logic any_pend;
    logic any_ius;
    logic ack_cycle;
    logic ack_edge;
    logic ack_done_q;
    logic ack_done_d;
    logic ack_win;
    logic fetch_fall;
    logic [7:0] fetched_byte;
    dci_fetch_e fst_q;
    dci_fetch_e fst_d;
    logic ret_hit;
    logic [7:0] vec_out;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic oe_q;
    logic oe_d;
    logic [7:0] fetch_bus_q;
    logic [7:0] fetch_bus_d;
    logic op_fetch_q;
    logic op_fetch_d;
    logic fetch_rise;
    logic ret_clear;
    logic chain_block;
    logic [2:0] top_idx;

    dci_sync #(.RST_VAL(1'b1)) u_sync_fetch (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_pin(i_fetch_cycle_n),
        .o_level(fetch_n_s)
    );

    dci_sync #(.RST_VAL(1'b1)) u_sync_io_request_n (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_pin(i_io_request_n),
        .o_level(io_request_n_n_s)
    );

    // Priority picks: first set bit from source 0.
    always_comb begin
        top_pend = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                top_pend = '0;
                top_pend[i] = 1'b1;
            end
        end
    end

    // The most recently acknowledged latch is always the highest one set, as nesting
    // only lets a higher source in.
    always_comb begin
        top_ius = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (ius_q[i]) begin
                top_ius = '0;
                top_ius[i] = 1'b1;
            end
        end
    end

    // A pending source only requests when no equal or higher one is in service.
    always_comb begin
        req_pend_mask = '0;
        for (int i = 0; i < N_SRC; i++) begin
            req_pend_mask[i] = pend_q[i] && ((ius_q & ((N_SRC'(1) << (i + 1)) - N_SRC'(1))) == '0);
        end
    end

    assign any_pend = |req_pend_mask;
    assign any_ius = |ius_q;

    // RULE8: after the return prefix, only in-service latches block the chain.
    // The opening lasts through the fetch that follows the prefix, until its byte is decoded.
    assign pend_blocked = (fst_q != DCI_IDLE) ? '0 : req_pend_mask;
    assign chain_block = any_ius || (|pend_blocked); // RULE4

    // The chain output is pure logic from the pin so ripple needs no clock.
    always_comb begin
        o_chain_enable_out = i_chain_enable_in && !chain_block; // RULE3 RULE4 RULE14
    end

    // RULE1: request low while a source may be acknowledged.
    assign o_int_n = !any_pend;

    assign ack_cycle = !fetch_n_s && !io_request_n_n_s; // RULE1
    assign ack_edge = ack_cycle && !ack_done_q;
    assign ack_win = ack_edge && i_chain_enable_in && any_pend; // RULE6
    assign grant = ack_win ? (top_pend & req_pend_mask) : '0;

    assign fetch_fall = fetch_n_prev_q && !fetch_n_s;
    assign fetch_rise = !fetch_n_prev_q && fetch_n_s;
    // An opcode fetch is a fetch strobe without io request; the byte is sampled at its start.
    assign fetched_byte = fetch_bus_q;

    always_comb begin
        fst_d = fst_q;
        ret_hit = 1'b0;
        if (fetch_fall && io_request_n_n_s) begin
            unique case (fst_q)
                DCI_IDLE: begin
                    fst_d = DCI_IDLE;
                end
                DCI_PREFIX: begin
                    // Only the fetch right after the prefix may carry the return byte.
                    fst_d = DCI_WAIT_END;
                end
                DCI_WAIT_END: begin
                    fst_d = DCI_IDLE;
                end
                default: begin
                    fst_d = DCI_IDLE;
                end
            endcase
        end
        if (fetch_rise && op_fetch_q) begin
            // End of an opcode fetch: the byte captured at its start is decoded now.
            if (fst_q == DCI_WAIT_END && fetched_byte == OPC_RETURN) begin
                ret_hit = 1'b1; // RULE9
                fst_d = DCI_IDLE;
            end else if (fetched_byte == OPC_PREFIX) begin
                fst_d = DCI_PREFIX; // RULE8
            end else begin
                fst_d = DCI_IDLE;
            end
        end
    end

    // RULE13: vector carries the top requester, or a fixed idle code.
    // Index of the top requester; the idle code stands when nothing requests.
    always_comb begin
        top_idx = VEC_IDLE_CODE;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req_pend_mask[i]) begin
                top_idx = 3'(i);
            end
        end
    end

    always_comb begin
        vec_out = i_vector_base;
        if (i_status_affects_vector) begin
            vec_out[3:1] = top_idx;
        end
    end

    // A fetched return clears a latch only in the member whose input is high and output low.
    assign ret_clear = (ret_hit && i_chain_enable_in) || i_sw_return; // RULE9 RULE12

    // Fetch watcher: strobe history, the captured opcode byte and whether it was a fetch.
    always_comb begin
        fetch_n_prev_d = fetch_n_s;
        fetch_bus_d = fetch_bus_q;
        op_fetch_d = op_fetch_q;
        if (fetch_fall) begin
            // The pin has been low for at least four cycles here, so the byte has settled.
            fetch_bus_d = i_data;
            op_fetch_d = io_request_n_n_s;
        end else if (!fetch_n_s) begin
            // An io request anywhere in the cycle turns it into an acknowledge.
            op_fetch_d = op_fetch_q && io_request_n_n_s;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fetch_n_prev_q <= 1'b1;
            fetch_bus_q <= VEC_BASE_RST;
            op_fetch_q <= 1'b0;
            fst_q <= DCI_IDLE;
        end else begin
            fetch_n_prev_q <= fetch_n_prev_d;
            fetch_bus_q <= fetch_bus_d;
            op_fetch_q <= op_fetch_d;
            fst_q <= fst_d;
        end
    end

    // Acknowledge: the vector loads once per cycle and stands until a strobe returns high.
    always_comb begin
        ack_done_d = ack_cycle ? (ack_done_q || ack_edge) : 1'b0;
        oe_d = ack_cycle && (oe_q || ack_win);
        data_d = data_q;
        if (ack_win) begin
            data_d = vec_out; // RULE6
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_done_q <= 1'b0;
            data_q <= VEC_BASE_RST;
            oe_q <= 1'b0;
        end else begin
            ack_done_q <= ack_done_d;
            data_q <= data_d;
            oe_q <= oe_d;
        end
    end

    // Status: pending copies follow the sources only while the fetch strobe is high.
    always_comb begin
        pend_d = pend_q;
        ius_d = ius_q;
        if (fetch_n_s) begin
            pend_d = i_src_req; // RULE5
        end
        if (ack_win) begin
            ius_d = ius_q | grant; // RULE6 RULE10
            pend_d = pend_q & ~grant;
        end
        if (ret_clear) begin
            // A latch granted in this cycle is not in top_ius, so its set wins.
            ius_d = ius_d & ~top_ius; // RULE9 RULE11 RULE12
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pend_q <= '0;
            ius_q <= '0;
        end else begin
            pend_q <= pend_d;
            ius_q <= ius_d;
        end
    end

    assign o_data = data_q;
    assign o_data_oe = oe_q;
    assign o_in_service = ius_q;
endmodule

/* src/dci_sync.sv */
// Three-stage pin synchroniser; a change counts once stages two and three agree.
`timescale 1ns/100ps
module dci_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_pin,
    output logic o_level
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic level_q;
    logic level_d;

    always_comb begin
        stage_d = {stage_q[1:0], i_pin};
        level_d = (stage_q[2] == stage_q[1]) ? stage_q[1] : level_q;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage_q <= {3{RST_VAL}};
            level_q <= RST_VAL;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
endmodule

/* verification/daisy_chain_interrupt_logic_test.sv */
// Self-checking bench for the daisy-chain interrupt logic.
`timescale 1ns/100ps
module daisy_chain_interrupt_logic_test;
    import dci_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [5:0] src = 6'h00;
    logic [7:0] base = 8'ha5;
    logic sav = 1'b1;
    logic swr = 1'b0;
    logic cin = 1'b1;
    logic fetch_n, io_n, oe, cout, int_n, got;
    logic [7:0] hdata, dout, vec;
    logic [5:0] isv;
    int n_fail = 0;
    int checks_done = 0;
    initial forever #12.5 i_clk = ~i_clk;
    dci_daisy_chain dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_src_req(src),
        .i_vector_base(base), .i_status_affects_vector(sav), .i_sw_return(swr),
        .i_chain_enable_in(cin), .i_fetch_cycle_n(fetch_n), .i_io_request_n(io_n),
        .i_data(hdata), .o_chain_enable_out(cout), .o_int_n(int_n), .o_data(dout),
        .o_data_oe(oe), .o_in_service(isv));
    dci_host_model host_u (.i_clk(i_clk), .i_oe(oe), .i_vec(dout), .o_fetch_n(fetch_n),
        .o_io_n(io_n), .o_data(hdata));
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic ret(input logic [7:0] second);
        host_u.cyc(1'b1, OPC_PREFIX, got, vec);
        host_u.cyc(1'b1, second, got, vec);
    endtask
    task automatic req(input logic [5:0] r);
        src <= r;
        repeat (4) @(posedge i_clk);
        chk(int_n === 1'b0 && cout === 1'b0, "no request");
    endtask
    task automatic t_idle;
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            cin <= k[0];
            #1 chk(cout === k[0], "chain not passed");
        end
        chk(int_n === 1'b1 && isv === 6'h00, "idle");
        @(posedge i_clk);
        $display("idle done");
    endtask
    task automatic t_refuse;
        cin <= 1'b0;
        req(6'h04);
        host_u.cyc(1'b0, 8'h00, got, vec);
        chk(got === 1'b0 && isv === 6'h00, "drove without grant");
        src <= 6'h00;
        cin <= 1'b1;
        repeat (4) @(posedge i_clk);
        $display("refuse done");
    endtask
    task automatic t_each;
        logic [7:0] ev;
        for (int i = 0; i < 6; i++) begin
            sav <= !i[0];
            req(6'(6'h01 << i));
            host_u.cyc(1'b0, 8'h00, got, vec);
            ev = i[0] ? base : {base[7:4], 3'(i), base[0]};
            chk(got === 1'b1 && vec === ev, "vector");
            chk(isv === 6'(6'h01 << i), "latch");
            src <= 6'h00;
            ret(OPC_RETURN);
            chk(isv === 6'h00 && cout === 1'b1, "return");
        end
        $display("each done");
    endtask
    task automatic t_nest;
        req(6'h20);
        host_u.cyc(1'b0, 8'h00, got, vec);
        req(6'h01);
        host_u.cyc(1'b0, 8'h00, got, vec);
        chk(isv === 6'h21, "nest");
        src <= 6'h00;
        ret(8'h00);
        chk(isv === 6'h21, "cancel");
        ret(OPC_RETURN);
        chk(isv === 6'h20, "inner return");
        swr <= 1'b1;
        @(posedge i_clk);
        swr <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(isv === 6'h00, "software return");
        $display("nest done");
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_idle;
        t_refuse;
        t_each;
        t_nest;
        close_out;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        close_out;
    end
endmodule

/* verification/dci_daisy_chain_asserts.sv */
// Port-level assertions for the daisy-chain interrupt logic.
`timescale 1ns/100ps
module dci_daisy_chain_asserts
    import dci_pkg::*;
#(
    parameter int unsigned N_SRC = NUM_SRC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [N_SRC-1:0] i_src_req,
    input wire logic [7:0] i_vector_base,
    input wire logic i_status_affects_vector,
    input wire logic i_sw_return,
    input wire logic i_chain_enable_in,
    input wire logic i_fetch_cycle_n,
    input wire logic i_io_request_n,
    input wire logic [7:0] i_data,
    input wire logic o_chain_enable_out,
    input wire logic o_int_n,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic [N_SRC-1:0] o_in_service
);
    default clocking dck @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_pass; (i_src_req == '0 && o_in_service == '0 && i_fetch_cycle_n)[*5]
        |-> o_chain_enable_out == i_chain_enable_in; endproperty
    a_pass: assert property (p_pass) else $error("chain not passed");
    property p_block; o_in_service != '0 |-> !o_chain_enable_out; endproperty
    a_block: assert property (p_block) else $error("chain not blocked");
    property p_int; $fell(o_int_n) |-> ($past(i_src_req) | $past(i_src_req, 2)) != '0; endproperty
    a_int: assert property (p_int) else $error("request without source");
    property p_ack; $rose(o_data_oe) |-> i_chain_enable_in && !i_io_request_n; endproperty
    a_ack: assert property (p_ack) else $error("vector without grant");
    property p_set; $rose(o_data_oe) |-> ##[0:2] o_in_service != '0; endproperty
    a_set: assert property (p_set) else $error("latch not set");
    property p_frz; (!i_fetch_cycle_n && i_io_request_n)[*8] |-> $stable(o_int_n); endproperty
    a_frz: assert property (p_frz) else $error("status moved in fetch");
    property p_vec; $rose(o_data_oe) && i_status_affects_vector |-> o_data[0] == i_vector_base[0]
        && o_data[7:4] == i_vector_base[7:4]; endproperty
    a_vec: assert property (p_vec) else $error("vector base bits");
    property p_swr; i_sw_return && $onehot(o_in_service) |-> ##[1:2] o_in_service == '0; endproperty
    a_swr: assert property (p_swr) else $error("software return");
endmodule
bind dci_daisy_chain dci_daisy_chain_asserts #(.N_SRC(N_SRC)) chk_u (.*);

/* verification/dci_host_model.sv */
// Host bus model: acknowledge and opcode fetch cycles.
`timescale 1ns/100ps
module dci_host_model (
    input wire logic i_clk,
    input wire logic i_oe,
    input wire logic [7:0] i_vec,
    output logic o_fetch_n = 1'b1,
    output logic o_io_n = 1'b1,
    output logic [7:0] o_data = 8'h00
);
    // Strobes hold eight cycles because the device sees them through a synchroniser.
    task automatic cyc(input logic io, input logic [7:0] b, output logic got,
        output logic [7:0] v);
        got = 1'b0;
        v = 8'h00;
        o_fetch_n <= 1'b0;
        o_io_n <= io;
        o_data <= b;
        repeat (8) begin
            @(posedge i_clk);
            if (!got && i_oe === 1'b1) begin
                got = 1'b1;
                v = i_vec;
            end
        end
        o_fetch_n <= 1'b1;
        o_io_n <= 1'b1;
        // A released bus must not keep showing the old opcode.
        o_data <= ~b;
        repeat (6) @(posedge i_clk);
    endtask
endmodule
